// file: sms_arb_retry.sv
// consecutive lost-arbitration counter with retry and abort
`timescale 1ns/1ps
`default_nettype none
module sms_arb_retry #(
   parameter int TRIES = sms_pkg::ARB_TRIES
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // arbitration results from the bus engine
   input  wire logic lost,
   input  wire logic won,
   // requests back to the bus engine
   output logic      retry,
   output logic      abort
);
   localparam int CW = $clog2(TRIES + 1);

   // refuse counts the counter cannot serve
   if (TRIES < 2 || TRIES > 31) begin : g_bad_tries
      $error("sms_arb_retry: TRIES out of range");
   end

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          retry;
      logic          abort;
   } sms_arb_s;

   sms_arb_s st_ff;
   sms_arb_s nxt_st;

   // loss counting, retry or abort on the last loss
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.retry = 1'b0;
      nxt_st.abort = 1'b0;
      if (won) begin
         nxt_st.cnt = '0;
      end else if (lost) begin
         if (st_ff.cnt == CW'(TRIES - 1)) begin
            nxt_st.abort = 1'b1;
            nxt_st.cnt   = '0;
         end else begin
            nxt_st.retry = 1'b1;
            nxt_st.cnt   = st_ff.cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign retry = st_ff.retry;
   assign abort = st_ff.abort;

   // checks
   retry_on_loss_a : assert property (@(posedge clk) disable iff (!rst_b)
      lost && !won && st_ff.cnt != CW'(TRIES - 1) |=> retry && !abort)
      else $error("lost arbitration not retried");
   abort_on_last_a : assert property (@(posedge clk) disable iff (!rst_b)
      abort |-> $past(lost) && !$past(won) && $past(st_ff.cnt) == CW'(TRIES - 1))
      else $error("abort without the last consecutive loss");
   abort_cov : cover property (@(posedge clk) disable iff (!rst_b) abort);
endmodule
`default_nettype wire

// file: sms_bus_peer.sv
// behavioural model of the bus engine and configuration loader side
`timescale 1ns/1ps
`default_nettype none
module sms_bus_peer (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // command from the bench
   input  wire logic       go,
   input  wire logic [2:0] kind,
   // answers from the status block
   input  wire logic       arb_retry,
   input  wire logic       arb_abort,
   // event pulses toward the status block
   output logic            nack_evt,
   output logic            arb_lost_evt,
   output logic            arb_won_evt,
   output logic            misplaced_evt,
   output logic            load_done_evt,
   output logic            csum_bad_evt,
   output logic            no_cfg_done_evt,
   output logic            unmapped_evt
);
   // one-cycle pulse per command; a rival master keeps winning every retry
   always_ff @(posedge clk) begin
      nack_evt        <= go && kind == 3'h0;
      arb_lost_evt    <= rst_b && ((go && kind == 3'h1) || (arb_retry && !arb_abort));
      misplaced_evt   <= go && kind == 3'h2;
      csum_bad_evt    <= go && kind == 3'h3;
      no_cfg_done_evt <= go && kind == 3'h4;
      unmapped_evt    <= go && kind == 3'h5;
      load_done_evt   <= go && kind == 3'h6;
      arb_won_evt     <= go && kind == 3'h7;
   end
endmodule
`default_nettype wire

// file: sms_pkg.sv
// constants and types of the bus status register block
// Operation
// - slave bus address read-only in bits 7:1
// - master bus address read-only in bits 15:9
// - bit 24 set when loading ends, in loading mode only
// - bit 25 flags unexpected NACK, write-one clears
// - lost arbitration retried without software help
// - 16 losses abort and set bit 26
// - bit 27 flags misplaced START or STOP
// - bit 28 flags bad loader checksum
// - missing configuration-complete also sets bit 28
// - bit 29 flags load to unmapped register
// - ignore-checksum control suppresses checksum errors
`default_nettype none
package sms_pkg;
   // register byte addresses
   localparam int          REG_AW   = 12;
   localparam logic [11:0] STS_OFS  = 12'h424;
   localparam logic [11:0] CTRL_OFS = 12'h428;
   localparam logic [11:0] MASK_OFS = 12'h42c;
   // status field positions
   localparam int ADDR_W    = 7;
   localparam int SLV_LSB   = 1;
   localparam int MST_LSB   = 9;
   localparam int DONE_BIT  = 24;
   localparam int ERR_LSB   = 25;
   localparam int ERR_W     = 5;
   // error flag index within the error field
   localparam int E_NACK    = 0;
   localparam int E_ARB     = 1;
   localparam int E_MISP    = 2;
   localparam int E_CSUM    = 3;
   localparam int E_UNMAP   = 4;
   // control field position
   localparam int IGN_BIT   = 17;
   // reset values
   localparam logic [4:0] ERR_RST  = 5'h00;
   localparam logic [4:0] MASK_RST = 5'h00;
   localparam logic       IGN_RST  = 1'b0;
   localparam logic       DONE_RST = 1'b0;
   // consecutive lost arbitrations before abort
   localparam int ARB_TRIES = 16;
   // strap capture sequence after reset release
   typedef enum logic [1:0] {
      SMS_CAP_W0   = 2'b00,
      SMS_CAP_W1   = 2'b01,
      SMS_CAP_TAKE = 2'b11,
      SMS_CAP_DONE = 2'b10
   } sms_cap_e;
endpackage
`default_nettype wire

// file: sms_status_regs.sv
// status register bank of the management buses and loader
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module sms_status_regs (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // register port
   input  wire logic [11:0] reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // hardware-init straps
   input  wire logic [6:0]  slave_addr_pin,
   input  wire logic [6:0]  master_addr_pin,
   input  wire logic        eeprom_mode_pin,
   // master bus engine
   input  wire logic        nack_evt,
   input  wire logic        arb_lost_evt,
   input  wire logic        arb_won_evt,
   input  wire logic        misplaced_evt,
   output logic             arb_retry,
   output logic             arb_abort,
   // configuration loader
   input  wire logic        load_done_evt,
   input  wire logic        csum_bad_evt,
   input  wire logic        no_cfg_done_evt,
   input  wire logic        unmapped_evt,
   output logic             ignore_checksum_ctrl,
   // interrupt
   output logic             irq
);
   localparam int AW = sms_pkg::ADDR_W;
   localparam int SW = 2 * AW + 1;
   localparam int EW = sms_pkg::ERR_W;

   // whole state of the bank apart from the arbitration counter in u_arb
   typedef struct packed {
      logic [SW-1:0]     sync1;
      logic [SW-1:0]     sync2;
      sms_pkg::sms_cap_e cap;
      logic [AW-1:0]     slv_addr;
      logic [AW-1:0]     mst_addr;
      logic              load_mode;
      logic              done;
      logic [EW-1:0]     err;
      logic [EW-1:0]     mask;
      logic              ign;
      logic [31:0]       rdata;
      logic              irq;
   } sms_st_s;

   localparam sms_st_s ST_RST = '{
      sync1:     '0,
      sync2:     '0,
      cap:       sms_pkg::SMS_CAP_W0,
      slv_addr:  '0,
      mst_addr:  '0,
      load_mode: 1'b0,
      done:      sms_pkg::DONE_RST,
      err:       sms_pkg::ERR_RST,
      mask:      sms_pkg::MASK_RST,
      ign:       sms_pkg::IGN_RST,
      rdata:     32'h0000_0000,
      irq:       1'b0
   };

   sms_st_s st_ff;
   sms_st_s nxt_st;

   logic          wr_sts;
   logic          wr_ctrl;
   logic          wr_mask;
   logic [EW-1:0] clr_v;
   logic [EW-1:0] set_v;
   logic          csum_set;
   logic          load_end;
   logic [31:0]   sts_word;
   logic [31:0]   ctrl_word;
   logic [31:0]   mask_word;
   logic          abort_w;
   logic          retry_w;

   // arbitration retry and abort counter
   sms_arb_retry #(
      .TRIES (sms_pkg::ARB_TRIES)
   ) u_arb (
      .clk   (clk),
      .rst_b (rst_b),
      .lost  (arb_lost_evt),
      .won   (arb_won_evt),
      .retry (retry_w),
      .abort (abort_w)
   );

   // write decode
   assign wr_sts  = reg_wr && reg_addr == sms_pkg::STS_OFS;
   assign wr_ctrl = reg_wr && reg_addr == sms_pkg::CTRL_OFS;
   assign wr_mask = reg_wr && reg_addr == sms_pkg::MASK_OFS;
   assign clr_v   = wr_sts ? reg_wdata[sms_pkg::ERR_LSB +: EW] : '0;

   // checksum error unless ignored; missing terminator always counts
   assign csum_set = (csum_bad_evt && !st_ff.ign) || no_cfg_done_evt;

   // hardware event vector in error field order
   always_comb begin
      set_v                   = '0;
      set_v[sms_pkg::E_NACK]  = nack_evt;
      set_v[sms_pkg::E_ARB]   = abort_w;
      set_v[sms_pkg::E_MISP]  = misplaced_evt;
      set_v[sms_pkg::E_CSUM]  = csum_set;
      set_v[sms_pkg::E_UNMAP] = unmapped_evt;
   end

   // loading ends on completion or on any loader error except a bad checksum while ignored
   assign load_end = load_done_evt || csum_set || unmapped_evt;

   // status word; reserved bits stay zero
   always_comb begin
      sts_word = 32'h0000_0000;
      sts_word[sms_pkg::SLV_LSB +: AW] = st_ff.slv_addr;
      sts_word[sms_pkg::MST_LSB +: AW] = st_ff.mst_addr;
      sts_word[sms_pkg::DONE_BIT]      = st_ff.done;
      sts_word[sms_pkg::ERR_LSB +: EW] = st_ff.err;
   end

   // control and mask words
   always_comb begin
      ctrl_word = 32'h0000_0000;
      ctrl_word[sms_pkg::IGN_BIT] = st_ff.ign;
      mask_word = 32'h0000_0000;
      mask_word[sms_pkg::ERR_LSB +: EW] = st_ff.mask;
   end

   // next state
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.sync1 = {eeprom_mode_pin, master_addr_pin, slave_addr_pin};
      nxt_st.sync2 = st_ff.sync1;
      // straps settle through the synchroniser, then are held
      case (st_ff.cap)
         sms_pkg::SMS_CAP_W0: begin
            nxt_st.cap = sms_pkg::SMS_CAP_W1;
         end
         sms_pkg::SMS_CAP_W1: begin
            nxt_st.cap = sms_pkg::SMS_CAP_TAKE;
         end
         sms_pkg::SMS_CAP_TAKE: begin
            nxt_st.slv_addr  = st_ff.sync2[AW-1:0];
            nxt_st.mst_addr  = st_ff.sync2[2*AW-1:AW];
            nxt_st.load_mode = st_ff.sync2[SW-1];
            nxt_st.cap       = sms_pkg::SMS_CAP_DONE;
         end
         sms_pkg::SMS_CAP_DONE: begin
            nxt_st.cap = sms_pkg::SMS_CAP_DONE;
         end
         default: begin
            nxt_st.cap = sms_pkg::SMS_CAP_W0;
         end
      endcase
      // loader complete, only in loading mode, held until reset
      if (st_ff.load_mode && load_end) begin
         nxt_st.done = 1'b1;
      end
      // sticky errors: a set in the clearing cycle wins
      nxt_st.err = (st_ff.err & ~clr_v) | set_v;
      if (wr_ctrl) begin
         nxt_st.ign = reg_wdata[sms_pkg::IGN_BIT];
      end
      if (wr_mask) begin
         nxt_st.mask = reg_wdata[sms_pkg::ERR_LSB +: EW];
      end
      // read data for the cycle after the strobe only
      nxt_st.rdata = 32'h0000_0000;
      if (reg_rd) begin
         case (reg_addr)
            sms_pkg::STS_OFS:  nxt_st.rdata = sts_word;
            sms_pkg::CTRL_OFS: nxt_st.rdata = ctrl_word;
            sms_pkg::MASK_OFS: nxt_st.rdata = mask_word;
            default:           nxt_st.rdata = 32'h0000_0000;
         endcase
      end
      nxt_st.irq = |(nxt_st.err & nxt_st.mask);
   end

   // state register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from flops
   assign reg_rdata            = st_ff.rdata;
   assign irq                  = st_ff.irq;
   assign ignore_checksum_ctrl = st_ff.ign;
   assign arb_retry            = retry_w;
   assign arb_abort            = abort_w;

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   slave_addr_read_a : assert property (
      reg_rd && reg_addr == sms_pkg::STS_OFS
      |=> reg_rdata[7:1] == st_ff.slv_addr)
      else $error("slave address not in status bits 7:1");

   master_addr_read_a : assert property (
      reg_rd && reg_addr == sms_pkg::STS_OFS
      |=> reg_rdata[15:9] == st_ff.mst_addr)
      else $error("master address not in status bits 15:9");

   addr_held_a : assert property (
      st_ff.cap == sms_pkg::SMS_CAP_DONE
      |=> $stable(st_ff.slv_addr) && $stable(st_ff.mst_addr))
      else $error("bus addresses changed after capture");

   done_set_a : assert property (
      st_ff.load_mode && load_done_evt
      |=> st_ff.done ##1 st_ff.done)
      else $error("loader complete not set or not held");

   done_mode_a : assert property (
      !st_ff.load_mode && !st_ff.done
      |=> !st_ff.done)
      else $error("loader complete set outside loading mode");

   nack_set_a : assert property (
      nack_evt ##1 (wr_sts && reg_wdata[25])
      |=> st_ff.err[sms_pkg::E_NACK] == $past(nack_evt))
      else $error("nack flag lost or not cleared");

   nack_clear_a : assert property (
      wr_sts && reg_wdata[25] && !nack_evt
      |=> !st_ff.err[sms_pkg::E_NACK])
      else $error("nack flag not cleared by writing one");

   arb_flag_a : assert property (
      arb_abort |=> st_ff.err[sms_pkg::E_ARB])
      else $error("arbitration abort did not set its flag");

   misplaced_a : assert property (
      misplaced_evt |=> st_ff.err[sms_pkg::E_MISP])
      else $error("misplaced condition flag not set");

   csum_set_a : assert property (
      csum_bad_evt && !ignore_checksum_ctrl
      |=> st_ff.err[sms_pkg::E_CSUM])
      else $error("checksum error flag not set");

   no_cfg_a : assert property (
      no_cfg_done_evt |=> st_ff.err[sms_pkg::E_CSUM])
      else $error("missing terminator did not flag checksum");

   unmapped_a : assert property (
      unmapped_evt |=> st_ff.err[sms_pkg::E_UNMAP])
      else $error("unmapped load flag not set");

   ignore_csum_a : assert property (
      ignore_checksum_ctrl && !no_cfg_done_evt
      && !st_ff.err[sms_pkg::E_CSUM]
      |=> !st_ff.err[sms_pkg::E_CSUM])
      else $error("checksum flag raised while ignored");

   reserved_zero_a : assert property (
      reg_rd && reg_addr == sms_pkg::STS_OFS
      |=> reg_rdata[0] == 1'b0 && reg_rdata[8] == 1'b0
      && reg_rdata[23:16] == 8'h00 && reg_rdata[31:30] == 2'h0)
      else $error("reserved status bits not zero");

   irq_level_a : assert property (
      irq == |(st_ff.err & st_ff.mask))
      else $error("interrupt does not follow masked flags");

   rdata_one_cycle_a : assert property (
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside the answer cycle");

   abort_cov : cover property (arb_abort ##1 irq);
   csum_cov  : cover property (csum_bad_evt ##1 st_ff.done);
   clear_cov : cover property (st_ff.err != '0 ##1 wr_sts ##1 st_ff.err == '0);
   retry_cov : cover property (arb_retry [*3]);
endmodule
`default_nettype wire

// file: tb_top.sv
// self-checking bench of the bus status register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk, rst_b, reg_wr, reg_rd, go, mode;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [6:0]  s_pin, m_pin;
   logic [2:0]  kind;
   logic        nack, lost, won, misp, done, csum, nocfg, unmap, retry, abort, ign, irq;
   integer      seed, mismatches, compares, exp, nret, i;
   int          kk[6] = '{6, 0, 2, 3, 4, 5};
   int          bb[6] = '{24, 25, 27, 28, 28, 29};

   sms_status_regs dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slave_addr_pin(s_pin),
      .master_addr_pin(m_pin), .eeprom_mode_pin(mode), .nack_evt(nack), .arb_lost_evt(lost),
      .arb_won_evt(won), .misplaced_evt(misp), .arb_retry(retry), .arb_abort(abort),
      .load_done_evt(done), .csum_bad_evt(csum), .no_cfg_done_evt(nocfg), .unmapped_evt(unmap),
      .ignore_checksum_ctrl(ign), .irq(irq));

   sms_bus_peer peer (.clk(clk), .rst_b(rst_b), .go(go), .kind(kind), .arb_retry(retry),
      .arb_abort(abort), .nack_evt(nack), .arb_lost_evt(lost), .arb_won_evt(won),
      .misplaced_evt(misp), .load_done_evt(done), .csum_bad_evt(csum), .no_cfg_done_evt(nocfg),
      .unmapped_evt(unmap));

   // clock generator
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      compares++;
      if (got !== want) begin
         mismatches++;
         $display("ERROR %0t got %h want %h", $time, got, want);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] w);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata, w);
   endtask

   // one command to the peer, then time for the flag to land
   task automatic fire(input logic [2:0] k);
      @(posedge clk);
      go   <= 1'b1;
      kind <= k;
      @(posedge clk);
      go   <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // watchdog against a hang
   initial begin
      #(50 * 4000);
      mismatches++;
      stop_test();
   end

   // main sequence
   initial begin
      seed = 33;
      mismatches = 0;
      compares = 0;
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 32'h0000_0000;
      go = 1'b0;
      mode = 1'b1;
      kind = 3'h0;
      s_pin = 7'($random(seed));
      m_pin = 7'($random(seed));
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      exp = (32'(m_pin) << 9) | (32'(s_pin) << 1);
      rd(sms_pkg::STS_OFS, exp);
      wr(sms_pkg::STS_OFS, 32'hc0ff_ffff);
      rd(sms_pkg::STS_OFS, exp);
      wr(12'h7f0, $random(seed));
      rd(12'h7f0, 32'h0000_0000);
      $display("test registers done");
      // six event kinds, all but arbitration lost and won: set, read, write one to clear (loader complete bit 24 stays set)
      for (i = 0; i < 6; i++) begin
         fire(3'(kk[i]));
         exp = exp | (32'h1 << bb[i]) | ((kk[i] > 2) ? 32'h0100_0000 : 32'h0);
         rd(sms_pkg::STS_OFS, exp);
         chk({31'h0, irq}, 32'h0);
         wr(sms_pkg::STS_OFS, 32'h1 << bb[i]);
         if (bb[i] != 24) exp = exp & ~(32'h1 << bb[i]);
         rd(sms_pkg::STS_OFS, exp);
      end
      $display("test events done");
      wr(sms_pkg::MASK_OFS, 32'h0200_0000);
      rd(sms_pkg::MASK_OFS, 32'h0200_0000);
      fire(3'h0);
      #1 chk({31'h0, irq}, 32'h1);
      wr(sms_pkg::STS_OFS, 32'h0200_0000);
      repeat (2) @(posedge clk);
      #1 chk({31'h0, irq}, 32'h0);
      $display("test interrupt done");
      fire(3'h7);
      // first loss, then count every retry pulse from the very next edge
      @(posedge clk);
      go   <= 1'b1;
      kind <= 3'h1;
      @(posedge clk);
      go   <= 1'b0;
      nret = 1;
      repeat (80) begin
         @(posedge clk);
         #1 if (retry === 1'b1) nret++;
         if (abort === 1'b1) break;
      end
      chk(nret, 32'd16);
      repeat (3) @(posedge clk);
      exp = exp | 32'h0400_0000;
      rd(sms_pkg::STS_OFS, exp);
      wr(sms_pkg::STS_OFS, 32'h0400_0000);
      exp = exp & ~32'h0400_0000;
      rd(sms_pkg::STS_OFS, exp);
      $display("test arbitration done");
      wr(sms_pkg::CTRL_OFS, 32'hffff_ffff);
      rd(sms_pkg::CTRL_OFS, 32'h0002_0000);
      chk({31'h0, ign}, 32'h1);
      fire(3'h3);
      rd(sms_pkg::STS_OFS, exp);
      fire(3'h4);
      exp = exp | 32'h1000_0000;
      rd(sms_pkg::STS_OFS, exp);
      $display("test ignore checksum done");
      // second reset with the loading strap low: loader complete stays clear
      @(posedge clk);
      rst_b <= 1'b0;
      mode  <= 1'b0;
      s_pin <= 7'($random(seed));
      m_pin <= 7'($random(seed));
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      exp = (32'(m_pin) << 9) | (32'(s_pin) << 1);
      rd(sms_pkg::STS_OFS, exp);
      fire(3'h6);
      fire(3'h5);
      exp = exp | 32'h2000_0000;
      rd(sms_pkg::STS_OFS, exp);
      $display("test strap low done");
      stop_test();
   end
endmodule
`default_nettype wire
